// *** verilog/tgm_pkg.sv ***
// Shared constants and types for the tone generator melody control block
package tgm_pkg;

	// ==========================================================
	// Register map
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] ADDR_HIGH_TONE_DIVISOR = 8'h11;
	localparam logic [7:0] ADDR_LOW_TONE_DIVISOR = 8'h12;
	localparam logic [7:0] ADDR_MELODY_CONTROL = 8'h13;
	localparam logic [7:0] ADDR_PIN_STATUS = 8'h14;

	// ==========================================================
	// Field positions
	localparam int MELODY_ENABLE_BIT = 0;
	localparam int PIN_PORT_FF_BIT = 0;
	localparam int PIN_LEVEL_BIT = 1;
	localparam int HIGH_ACTIVE_BIT = 2;
	localparam int LOW_ACTIVE_BIT = 3;
	localparam int GEN_ACTIVE_BIT = 4;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RST_DIVISOR = 8'h00;
	localparam logic RST_MELODY_ENABLE = 1'b0;
	localparam logic RST_PORT_FF = 1'b1;

	// ==========================================================
	// Synthesizer timing: period is 23 * (x + 2) clocks
	localparam logic [4:0] STEPS_PER_PERIOD = 5'h17;
	localparam logic [4:0] LAST_STEP = 5'h16;
	localparam logic [4:0] DUTY_HIGH_STEPS = 5'h0c;
	localparam logic [8:0] DIVISOR_OFFSET = 9'h002;

	// ==========================================================
	// Tone sum: low group about 2 dB below high group
	localparam logic signed [7:0] LOW_ATTEN_NUM = 8'sh33;
	localparam int LOW_ATTEN_SHIFT = 6;
	localparam logic [9:0] TONE_MIDSCALE = 10'h200;

	// ==========================================================
	// Synthesizer states
	typedef enum logic [1:0] {
		SYN_IDLE = 2'b01,
		SYN_RUN = 2'b10
	} tgm_syn_state_t;

endpackage

// *** verilog/tgm_synth.sv ***
// One digital synthesizer channel: sine sample and 12/23 square wave
`timescale 1ns/100ps
module tgm_synth (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Divisor from its register
	input wire logic [7:0] divisor,
	// Channel outputs
	output logic signed [7:0] sample,
	output logic square,
	output logic active
);

	tgm_pkg::tgm_syn_state_t state;
	logic [7:0] cur_div;
	logic [8:0] pre_cnt;
	logic [4:0] phase;

	wire div_zero = (divisor == 8'h00);
	wire [8:0] pre_last = {1'b0, cur_div} + tgm_pkg::DIVISOR_OFFSET - 9'h001;
	wire step = (pre_cnt == pre_last);
	wire period_end = step && (phase == tgm_pkg::LAST_STEP);

	// Prescaler runs x+2 clocks per step, 23 steps per period
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= tgm_pkg::SYN_IDLE;
			cur_div <= tgm_pkg::RST_DIVISOR;
			pre_cnt <= 9'h000;
			phase <= 5'h00;
		end else begin
			case (state)
				tgm_pkg::SYN_IDLE: begin
					pre_cnt <= 9'h000;
					phase <= 5'h00;
					if (!div_zero) begin
						cur_div <= divisor;
						state <= tgm_pkg::SYN_RUN;
					end
				end
				tgm_pkg::SYN_RUN: begin
					if (div_zero) begin
						state <= tgm_pkg::SYN_IDLE; // RULE12
					end else if (step) begin
						pre_cnt <= 9'h000;
						phase <= period_end ? 5'h00 : phase + 5'h01;
						if (period_end) begin
							cur_div <= divisor; // RULE15
						end
					end else begin
						pre_cnt <= pre_cnt + 9'h001;
					end
				end
				default: begin
					state <= tgm_pkg::SYN_IDLE;
				end
			endcase
		end
	end

	// 23-point sine table, amplitude 120
	function automatic logic signed [7:0] sine_of(input logic [4:0] p);
		case (p)
			5'h00: sine_of = 8'sh00;
			5'h01: sine_of = 8'sh20;
			5'h02: sine_of = 8'sh3e;
			5'h03: sine_of = 8'sh58;
			5'h04: sine_of = 8'sh6b;
			5'h05: sine_of = 8'sh75;
			5'h06: sine_of = 8'sh78;
			5'h07: sine_of = 8'sh71;
			5'h08: sine_of = 8'sh62;
			5'h09: sine_of = 8'sh4c;
			5'h0a: sine_of = 8'sh30;
			5'h0b: sine_of = 8'sh10;
			5'h0c: sine_of = -8'sh10;
			5'h0d: sine_of = -8'sh30;
			5'h0e: sine_of = -8'sh4c;
			5'h0f: sine_of = -8'sh62;
			5'h10: sine_of = -8'sh71;
			5'h11: sine_of = -8'sh78;
			5'h12: sine_of = -8'sh75;
			5'h13: sine_of = -8'sh6b;
			5'h14: sine_of = -8'sh58;
			5'h15: sine_of = -8'sh3e;
			5'h16: sine_of = -8'sh20;
			default: sine_of = 8'sh00;
		endcase
	endfunction

	assign active = (state == tgm_pkg::SYN_RUN);
	assign sample = active ? sine_of(phase) : 8'sh00; // RULE10
	assign square = active && (phase < tgm_pkg::DUTY_HIGH_STEPS); // RULE13

endmodule

// *** verilog/tgm_quasi_pin.sv ***
// Quasi-bidirectional port line shared with the melody square wave
`timescale 1ns/100ps
module tgm_quasi_pin (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Port flip-flop access
	input wire logic port_wr,
	input wire logic port_wdata,
	output logic port_ff,
	output logic pin_level,
	// Melody source
	input wire logic melody_enable,
	input wire logic melody_level,
	// Pad
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe
);

	logic sync_a;
	logic sync_b;

	// Melody only pulls low; a set port flip-flop lets it through
	wire drive_level = melody_enable ? (port_ff & melody_level) : port_ff; // RULE5 RULE6 RULE8

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			port_ff <= tgm_pkg::RST_PORT_FF;
			sync_a <= 1'b1;
			sync_b <= 1'b1;
			pin_out <= 1'b1;
			pin_oe <= 1'b0;
		end else begin
			if (port_wr) begin
				port_ff <= port_wdata; // RULE7
			end
			sync_a <= pin_in;
			sync_b <= sync_a;
			// High is left to the pull-up, low is driven hard
			pin_out <= drive_level;
			pin_oe <= ~drive_level;
		end
	end

	assign pin_level = sync_b; // RULE7

endmodule

// *** verilog/tgm_tone_ctrl.sv ***
// Tone generator control: divisor and melody registers, tone sum, melody pin
//
// Function
// RULE1 - Tone output released while no channel runs
// RULE2 - Write-only divisors at 11H and 12H
// RULE3 - Read/write melody control at 13H
// RULE4 - Melody control bits seven to one zero
// RULE5 - Enable clear: pin is plain port line
// RULE6 - Enable set: melody square wave on pin
// RULE7 - Port flip-flop and pin stay accessible
// RULE8 - Software keeps port flip-flop high meanwhile
// RULE9 - High divisor zero with enable: pin high
// RULE10 - Sine on tone output, square on pin
// RULE11 - Frequency is clock over 23(x+2)
// RULE12 - Zero divisor stops channel; both stop generator
// RULE13 - Melody from high divisor, duty 12/23
// RULE14 - Reset clears divisors and melody enable
// RULE15 - New divisor applied at period boundary
`timescale 1ns/100ps
module tgm_tone_ctrl (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	// Tone output sample and its enable
	output logic [9:0] tone_sample,
	output logic tone_oe,
	// Shared melody pin
	input wire logic shared_melody_pin_in,
	output logic shared_melody_pin_out,
	output logic shared_melody_pin_oe
);

	// ==========================================================
	// Registers
	logic [7:0] high_tone_divisor;
	logic [7:0] low_tone_divisor;
	logic melody_enable;

	wire sel_high = (addr == tgm_pkg::ADDR_HIGH_TONE_DIVISOR);
	wire sel_low = (addr == tgm_pkg::ADDR_LOW_TONE_DIVISOR);
	wire sel_mel = (addr == tgm_pkg::ADDR_MELODY_CONTROL);
	wire sel_pin = (addr == tgm_pkg::ADDR_PIN_STATUS);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			high_tone_divisor <= tgm_pkg::RST_DIVISOR; // RULE14
			low_tone_divisor <= tgm_pkg::RST_DIVISOR; // RULE14
			melody_enable <= tgm_pkg::RST_MELODY_ENABLE; // RULE14
		end else if (wr_en) begin
			if (sel_high) begin
				high_tone_divisor <= wr_data; // RULE2
			end
			if (sel_low) begin
				low_tone_divisor <= wr_data; // RULE2
			end
			if (sel_mel) begin
				melody_enable <= wr_data[tgm_pkg::MELODY_ENABLE_BIT]; // RULE3
			end
		end
	end

	// ==========================================================
	// Synthesizers
	logic signed [7:0] high_sample;
	logic signed [7:0] low_sample;
	logic high_square;
	logic high_active;
	logic low_active;

	// Each channel runs at clk / (23 * (x + 2))
	tgm_synth u_high ( // RULE11
		.clk(clk),
		.rst_n(rst_n),
		.divisor(high_tone_divisor),
		.sample(high_sample),
		.square(high_square),
		.active(high_active)
	);

	tgm_synth u_low ( // RULE11
		.clk(clk),
		.rst_n(rst_n),
		.divisor(low_tone_divisor),
		.sample(low_sample),
		.square(),
		.active(low_active)
	);

	// ==========================================================
	// Tone sum
	wire gen_active = high_active | low_active; // RULE12
	wire signed [15:0] low_scaled_full = low_sample * tgm_pkg::LOW_ATTEN_NUM;
	wire signed [9:0] low_scaled = 10'(low_scaled_full >>> tgm_pkg::LOW_ATTEN_SHIFT);
	wire signed [9:0] tone_sum = 10'(high_sample) + low_scaled;
	wire [9:0] tone_code = tgm_pkg::TONE_MIDSCALE + $unsigned(tone_sum); // RULE10

	// Sample is parked at midscale so the DAC settles quietly when released
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tone_sample <= tgm_pkg::TONE_MIDSCALE;
			tone_oe <= 1'b0;
		end else begin
			tone_sample <= gen_active ? tone_code : tgm_pkg::TONE_MIDSCALE;
			tone_oe <= gen_active; // RULE1
		end
	end

	// ==========================================================
	// Melody pin
	logic port_ff;
	logic pin_level;

	// A zero high divisor holds the melody level high, so the pin idles high.
	// The channel starts a cycle after its write, so the level stays high until
	// the square runs; otherwise a one-cycle low glitch would appear on the pin.
	wire melody_idle = (high_tone_divisor == 8'h00) || !high_active;
	wire melody_level = melody_idle ? 1'b1 : high_square; // RULE9 RULE13
	wire port_wr = wr_en && sel_pin;

	tgm_quasi_pin u_pin (
		.clk(clk),
		.rst_n(rst_n),
		.port_wr(port_wr),
		.port_wdata(wr_data[tgm_pkg::PIN_PORT_FF_BIT]),
		.port_ff(port_ff),
		.pin_level(pin_level),
		.melody_enable(melody_enable),
		.melody_level(melody_level),
		.pin_in(shared_melody_pin_in),
		.pin_out(shared_melody_pin_out),
		.pin_oe(shared_melody_pin_oe)
	);

	// ==========================================================
	// Read path
	wire [7:0] mel_read = {7'h00, melody_enable}; // RULE4
	wire [7:0] pin_read = {3'h0, gen_active, low_active, high_active, pin_level, port_ff}; // RULE7
	// Divisors are write-only and read back as zero, like unmapped space
	wire [7:0] next_rd_data = !rd_en ? 8'h00 : sel_mel ? mel_read : sel_pin ? pin_read : 8'h00;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= next_rd_data; // RULE3
		end
	end

endmodule

// *** dv/tgm_tone_ctrl_sva.sv ***
// Port assertions for the tone control block
`timescale 1ns/100ps
module tgm_tone_ctrl_sva (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] rd_data,
	// Tone and pin
	input wire logic [9:0] tone_sample,
	input wire logic tone_oe,
	input wire logic shared_melody_pin_in,
	input wire logic shared_melody_pin_out,
	input wire logic shared_melody_pin_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ========
	// Registers
	a_read_idle_zero: assert property (!$past(rd_en) |-> rd_data == 8'h00)
		else $error("read data outside its cycle");
	a_ctl_upper_zero: assert property ($past(rd_en) && $past(addr) == 8'h13 |-> rd_data[7:1] == 7'h00)
		else $error("melody control upper bits set");
	a_div_read_zero: assert property ($past(rd_en) && ($past(addr) == 8'h11 || $past(addr) == 8'h12)
		|-> rd_data == 8'h00)
		else $error("divisor readable");
	a_reset_release: assert property ($rose(rst_n) |-> !tone_oe && !shared_melody_pin_oe)
		else $error("outputs not at reset level");
	// ========
	// Tone output
	a_start_tone_out: assert property (wr_en && addr == 8'h11 && wr_data != 8'h00 && !tone_oe
		|-> ##3 tone_oe)
		else $error("tone output not started");
	a_oe_cause: assert property ($rose(tone_oe) |-> $past(wr_en, 3) && $past(wr_data, 3) != 8'h00)
		else $error("tone output enabled without a start");
	a_tone_parked: assert property (!tone_oe |-> tone_sample == 10'h200)
		else $error("tone sample not parked while released");
	// ========
	// Shared pin
	a_pin_low_only: assert property (shared_melody_pin_oe |-> !shared_melody_pin_out)
		else $error("pin driven high");
	a_port_low_drive: assert property (wr_en && addr == 8'h14 && !wr_data[0]
		|-> ##2 shared_melody_pin_oe)
		else $error("port flip-flop low not driven");
	c_read_ctl: cover property (rd_en && addr == 8'h13);
	c_tone_on: cover property ($rose(tone_oe));
	c_pin_low: cover property ($rose(shared_melody_pin_oe));
endmodule

// *** dv/tgm_pad_model.sv ***
// Pad model of the shared quasi-bidirectional line
`timescale 1ns/100ps
module tgm_pad_model (
	// Drive from the block
	input wire logic pin_out,
	input wire logic pin_oe,
	// Resolved pad level
	output logic pad
);
	// Pull-up supplies the high level; the block only pulls low
	assign pad = pin_oe ? pin_out : 1'b1;
endmodule

// *** dv/tgm_tone_ctrl_bench.sv ***
// Self-checking bench for the tone control block
`timescale 1ns/100ps
module tgm_tone_ctrl_bench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wr_data = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic rd_pend = 1'b0;
	logic [7:0] rd_data;
	logic [9:0] tone_sample;
	logic tone_oe;
	logic pin_out;
	logic pin_oe;
	logic pad;
	logic [31:0] lfsr = 32'ha4aca4ab;
	logic [7:0] exp_q[$];
	int failures = 0;
	int num_checks = 0;
	int x;
	int n;
	always #25 clk = ~clk;
	tgm_tone_ctrl tgm_tone_ctrl_inst (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .tone_sample(tone_sample),
		.tone_oe(tone_oe), .shared_melody_pin_in(pad), .shared_melody_pin_out(pin_out),
		.shared_melody_pin_oe(pin_oe));
	tgm_pad_model tgm_pad_model_inst (.pin_out(pin_out), .pin_oe(pin_oe), .pad(pad));
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] s);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		wr_en <= w;
		rd_en <= r;
		addr <= a;
		wr_data <= d;
		@(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		bus(1'b0, 1'b1, a, 8'h00);
	endtask
	task automatic idle(input int k);
		bus(1'b0, 1'b0, 8'h00, 8'h00);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// Counts cycles the pad stays at one level
	task automatic span(input logic lvl, output int c);
		c = 0;
		while (pad === lvl && c < 3000) begin
			@(posedge clk);
			#1;
			c++;
		end
	endtask
	task automatic results;
		if (failures == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// ========
	// Read monitor: read data stand only in the cycle after the strobe
	always @(posedge clk) rd_pend <= rd_en;
	always @(negedge clk) begin
		if (rd_pend) begin
			chk8("rd_data", exp_q.pop_front(), rd_data);
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		results();
	end
	// ========
	// Main sequence
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		idle(0);
		chk8("tone_oe", 8'h00, {7'h00, tone_oe});
		chk8("tone_sample", 8'h80, tone_sample[9:2]);
		rd(8'h13, 8'h00);
		rd(8'h14, 8'h03);
		rd(8'h11, 8'h00);
		rd(8'h20, 8'h00);
		for (int i = 0; i < 4; i++) begin
			lfsr = next_rand(lfsr);
			wr(8'h13, lfsr[7:0]);
			rd(8'h13, {7'h00, lfsr[0]});
		end
		x = 2 + lfsr[10:8] % 6;
		// Port flip-flop stays high while melody is on
		wr(8'h14, 8'h01);
		wr(8'h13, 8'h01);
		wr(8'h11, x[7:0]);
		idle(2);
		chk8("tone_oe", 8'h01, {7'h00, tone_oe});
		span(1'b1, n);
		span(1'b0, n);
		chk8("low span", 8'(11 * (x + 2)), 8'(n));
		span(1'b1, n);
		chk8("high span", 8'(12 * (x + 2)), 8'(n));
		wr(8'h11, 8'h00);
		repeat (30) begin
			idle(0);
			chk8("melody pin", 8'h01, {7'h00, pad});
		end
		chk8("tone_oe", 8'h00, {7'h00, tone_oe});
		rd(8'h14, 8'h03);
		wr(8'h13, 8'h00);
		wr(8'h14, 8'h00);
		idle(3);
		chk8("port pin", 8'h00, {7'h00, pad});
		rd(8'h14, 8'h00);
		wr(8'h14, 8'h01);
		wr(8'h12, 8'h3c);
		idle(1);
		chk8("tone_oe", 8'h01, {7'h00, tone_oe});
		wr(8'h11, 8'h02);
		repeat (60) begin
			idle(0);
			chk8("port pin", 8'h01, {7'h00, pad});
		end
		rd(8'h14, 8'h1f);
		wr(8'h11, 8'h00);
		wr(8'h12, 8'h00);
		idle(3);
		chk8("tone_oe", 8'h00, {7'h00, tone_oe});
		chk8("tone_sample", 8'h80, tone_sample[9:2]);
		idle(2);
		results();
	end
endmodule
bind tgm_tone_ctrl tgm_tone_ctrl_sva tgm_tone_ctrl_sva_inst (.clk(clk), .rst_n(rst_n),
	.addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
	.tone_sample(tone_sample), .tone_oe(tone_oe), .shared_melody_pin_in(shared_melody_pin_in),
	.shared_melody_pin_out(shared_melody_pin_out), .shared_melody_pin_oe(shared_melody_pin_oe));
